// File: src/sync_line_pkg.sv
// constants, register map and carrier types for the serial line transmitter/receiver
`default_nettype none
package sync_line_pkg;
  localparam int DATA_W = 8;
  localparam int ADDR_W = 3;

  // register offsets on the plain register port
  localparam logic [ADDR_W-1:0] ADDR_RX_CSR = 3'h0;
  localparam logic [ADDR_W-1:0] ADDR_RX_BUF = 3'h1;
  localparam logic [ADDR_W-1:0] ADDR_PARAM = 3'h2;
  localparam logic [ADDR_W-1:0] ADDR_FILL = 3'h3;
  localparam logic [ADDR_W-1:0] ADDR_TX_CSR = 3'h4;
  localparam logic [ADDR_W-1:0] ADDR_TX_BUF = 3'h5;

  // rx_control_status fields
  localparam int RX_HUNT_BIT = 0;
  localparam int RX_DISCARD_BIT = 1;
  localparam int RX_IRQ_EN_BIT = 2;
  localparam int RX_SYNCED_BIT = 3;
  localparam int RX_READY_BIT = 4;
  localparam int RX_OVERRUN_BIT = 5;
  localparam int RX_FRAMING_BIT = 6;

  // tx_control_status fields
  localparam int TX_SEND_BIT = 0;
  localparam int TX_HALF_DUPLEX_SELECT_BIT = 1;
  localparam int TX_TAKEN_EN_BIT = 2;
  localparam int TX_URUN_EN_BIT = 3;
  localparam int TX_TAKEN_BIT = 4;
  localparam int TX_URUN_BIT = 5;

  // line_parameter_reg: low six bits hold line_param_t, top bit is master clear
  localparam int PARAM_W = 6;
  localparam int MCLR_BIT = 7;

  // reset values
  localparam logic [DATA_W-1:0] FILL_RST = 8'hFF;
  localparam logic [DATA_W-1:0] TXBUF_RST = 8'hFF;

  // framing constants
  localparam logic [3:0] MIN_CHAR_LEN = 4'h5;
  localparam int MAX_FRAME = 11;
  localparam int HUNT_W = 9;
  localparam logic [1:0] HOLD_BITS = 2'h2;

  typedef enum logic [1:0] {MODE_INT_SYNC, MODE_EXT_SYNC, MODE_ISO, MODE_SPARE} line_mode_t;

  typedef struct packed {
    line_mode_t mode;
    logic [1:0] len_code;
    logic par_en;
    logic par_odd;
  } line_param_t;

  typedef struct packed {
    logic [MAX_FRAME-1:0] bits;
    logic [3:0] count;
  } frame_t;
endpackage
`default_nettype wire

// File: src/sync_serial_line_tx_rx.sv
// single-line character serial transmitter and receiver with fill insertion and hunt
//
// Our own choices: the register offsets and strobed register access.
`timescale 1ns/10ps
`default_nettype none
module sync_serial_line_tx_rx #(
  parameter bit TWO_FILL_HUNT = 1'b1
) (
  // clock, reset, clock enable
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // register port
  input wire logic [sync_line_pkg::ADDR_W-1:0] addr,
  input wire logic [sync_line_pkg::DATA_W-1:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [sync_line_pkg::DATA_W-1:0] rdata,
  // serial line to modem
  input wire logic tx_line_clk,
  input wire logic rx_line_clk,
  input wire logic rx_data_in,
  output logic tx_data_out,
  // interrupt request with source
  output logic irq_req,
  output logic irq_from_rx
);

  ////////////////////////////////////////////////////////////////////////////
  // frame building helpers
  function automatic sync_line_pkg::frame_t build_frame(
    input logic [7:0] data, input sync_line_pkg::line_param_t p, input logic iso);
    sync_line_pkg::frame_t f;
    logic [3:0] len;
    logic par;
    f.bits = '1;
    f.count = 4'h0;
    len = sync_line_pkg::MIN_CHAR_LEN + {2'h0, p.len_code};
    par = p.par_odd;
    if (iso) begin
      f.bits[0] = 1'b0;
      f.count = 4'h1;
    end
    for (int i = 0; i < 8; i++) begin
      if (4'(i) < len) begin
        f.bits[f.count] = data[i];
        par = par ^ data[i];
        f.count = f.count + 4'h1;
      end
    end
    if (p.par_en) begin
      f.bits[f.count] = par;
      f.count = f.count + 4'h1;
    end
    if (iso) begin
      f.bits[f.count] = 1'b1;
      f.count = f.count + 4'h1;
    end
    return f;
  endfunction

  function automatic logic [10:0] low_mask(input logic [3:0] n);
    return (11'h001 << n) - 11'h001;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // registers and decode
  logic [7:0] fill_r, txbuf_r, rxbuf_r;
  sync_line_pkg::line_param_t param_r;
  logic hunt_r, discard_r, rx_en_irq_r, synced_r, ready_r, ovr_r, frm_r;
  logic send_r, hd_r, taken_en_r, urun_en_r, taken_r, urun_r, buf_full_r;
  logic tx_req_r, rx_req_r;
  logic wr_fill, wr_txbuf, wr_param, wr_tx_control_status, wr_rx_control_status, rd_tx_control_status, rd_rxbuf, mclr;
  logic iso, rx_en;

  assign wr_fill = ce & wr & (addr == sync_line_pkg::ADDR_FILL);
  assign wr_txbuf = ce & wr & (addr == sync_line_pkg::ADDR_TX_BUF);
  assign wr_param = ce & wr & (addr == sync_line_pkg::ADDR_PARAM);
  assign wr_tx_control_status = ce & wr & (addr == sync_line_pkg::ADDR_TX_CSR);
  assign wr_rx_control_status = ce & wr & (addr == sync_line_pkg::ADDR_RX_CSR);
  assign rd_tx_control_status = ce & rd & (addr == sync_line_pkg::ADDR_TX_CSR);
  assign rd_rxbuf = ce & rd & (addr == sync_line_pkg::ADDR_RX_BUF);
  assign mclr = wr_param & wdata[sync_line_pkg::MCLR_BIT];
  assign iso = (param_r.mode == sync_line_pkg::MODE_ISO);
  // half duplex keeps the receiver deaf while we talk
  assign rx_en = hunt_r & ~(hd_r & send_r);

  // software-owned control bits; master clear returns them all to reset state
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      fill_r <= sync_line_pkg::FILL_RST;
      param_r <= '0;
      {hunt_r, discard_r, rx_en_irq_r} <= 3'h0;
      {send_r, hd_r, taken_en_r, urun_en_r} <= 4'h0;
    end else if (ce) begin
      if (mclr) begin
        fill_r <= sync_line_pkg::FILL_RST;
        param_r <= '0;
        {hunt_r, discard_r, rx_en_irq_r} <= 3'h0;
        {send_r, hd_r, taken_en_r, urun_en_r} <= 4'h0;
      end else begin
        if (wr_fill) fill_r <= wdata;
        if (wr_param) param_r <= wdata[sync_line_pkg::PARAM_W-1:0];
        if (wr_rx_control_status) begin
          hunt_r <= wdata[sync_line_pkg::RX_HUNT_BIT];
          discard_r <= wdata[sync_line_pkg::RX_DISCARD_BIT];
          rx_en_irq_r <= wdata[sync_line_pkg::RX_IRQ_EN_BIT];
        end
        if (wr_tx_control_status) begin
          send_r <= wdata[sync_line_pkg::TX_SEND_BIT];
          hd_r <= wdata[sync_line_pkg::TX_HALF_DUPLEX_SELECT_BIT];
          taken_en_r <= wdata[sync_line_pkg::TX_TAKEN_EN_BIT];
          urun_en_r <= wdata[sync_line_pkg::TX_URUN_EN_BIT];
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // line clock and data synchronisers, edge detection on the second stage
  logic [1:0] txc_s, rxc_s, rxd_s;
  logic txc_d, rxc_d, tx_fall, rx_rise, rx_bit;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      txc_s <= 2'h0;
      rxc_s <= 2'h0;
      rxd_s <= 2'h3;
      txc_d <= 1'b0;
      rxc_d <= 1'b0;
    end else if (ce) begin
      txc_s <= {txc_s[0], tx_line_clk};
      rxc_s <= {rxc_s[0], rx_line_clk};
      rxd_s <= {rxd_s[0], rx_data_in};
      txc_d <= txc_s[1];
      rxc_d <= rxc_s[1];
    end
  end

  // transmit changes on the falling edge so the modem samples a settled bit
  assign tx_fall = ce & txc_d & ~txc_s[1];
  assign rx_rise = ce & ~rxc_d & rxc_s[1];
  assign rx_bit = rxd_s[1];

  ////////////////////////////////////////////////////////////////////////////
  // transmitter_unit
  typedef enum logic {TX_IDLE, TX_SHIFT} tx_state_t;
  tx_state_t tx_state_r;
  logic [sync_line_pkg::MAX_FRAME-1:0] tx_sr_r;
  logic [3:0] tx_cnt_r, tx_idx_r, first_pos, cur_pos;
  logic tx_line_r, tx_src_fill_r;
  logic at_end, do_reload, go_idle, new_src_fill, cur_fill, bit_evt, taken_evt, urun_evt;
  sync_line_pkg::frame_t next_frame;

  assign at_end = (tx_state_r == TX_SHIFT) & (tx_idx_r == tx_cnt_r);
  // a waiting character always beats the fill; isochronous never fills
  assign new_src_fill = ~buf_full_r;
  assign next_frame = build_frame(new_src_fill ? fill_r : txbuf_r, param_r, iso);
  assign do_reload = tx_fall & send_r & (((tx_state_r == TX_IDLE) & buf_full_r) |
                     (at_end & (buf_full_r | ~iso)));
  assign go_idle = tx_fall & at_end & ~do_reload;
  assign first_pos = iso ? 4'h1 : 4'h0;
  assign cur_pos = do_reload ? 4'h0 : tx_idx_r;
  assign cur_fill = do_reload ? new_src_fill : tx_src_fill_r;
  assign bit_evt = do_reload | (tx_fall & (tx_state_r == TX_SHIFT) & ~at_end);
  assign taken_evt = bit_evt & (cur_pos == first_pos) & ~cur_fill;
  assign urun_evt = bit_evt & (cur_pos == first_pos) & cur_fill;

  // shift engine, lsb first, one bit per line clock
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tx_state_r <= TX_IDLE;
      tx_sr_r <= '1;
      tx_cnt_r <= 4'h0;
      tx_idx_r <= 4'h0;
      tx_line_r <= 1'b1;
      tx_src_fill_r <= 1'b0;
    end else if (ce) begin
      if (mclr) begin
        tx_state_r <= TX_IDLE;
        tx_line_r <= 1'b1;
      end else if (do_reload) begin
        tx_state_r <= TX_SHIFT;
        tx_sr_r <= next_frame.bits;
        tx_cnt_r <= next_frame.count;
        tx_idx_r <= 4'h1;
        tx_line_r <= next_frame.bits[0];
        tx_src_fill_r <= new_src_fill;
      end else if (go_idle) begin
        tx_state_r <= TX_IDLE;
        tx_line_r <= 1'b1;
      end else if (bit_evt) begin
        tx_line_r <= tx_sr_r[tx_idx_r];
        tx_idx_r <= tx_idx_r + 4'h1;
      end
    end
  end

  // holding buffer: reset to ones, full until the shifter takes it
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      txbuf_r <= sync_line_pkg::TXBUF_RST;
      buf_full_r <= 1'b0;
    end else if (ce) begin
      if (mclr) begin
        txbuf_r <= sync_line_pkg::TXBUF_RST;
        buf_full_r <= 1'b0;
      end else if (wr_txbuf) begin
        txbuf_r <= wdata;
        buf_full_r <= 1'b1; // write wins over a same-cycle take
      end else if (do_reload & ~new_src_fill) begin
        buf_full_r <= 1'b0;
      end
    end
  end

  // transmit flags and request; setting events win over clearing accesses
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      taken_r <= 1'b0;
      urun_r <= 1'b0;
      tx_req_r <= 1'b0;
    end else if (ce) begin
      if (mclr) begin
        taken_r <= 1'b0;
        urun_r <= 1'b0;
        tx_req_r <= 1'b0;
      end else begin
        if (taken_evt) taken_r <= 1'b1;
        else if (wr_txbuf | ~send_r) taken_r <= 1'b0;
        if (urun_evt) urun_r <= 1'b1;
        else if (rd_tx_control_status) urun_r <= 1'b0;
        if ((taken_evt & taken_en_r) | (urun_evt & urun_en_r)) tx_req_r <= 1'b1;
        else if (rd_tx_control_status | wr_txbuf) tx_req_r <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // receiver_unit
  typedef enum logic [2:0] {RX_OFF, RX_HUNT, RX_HOLD, RX_START, RX_DATA, RX_STOP} rx_state_t;
  rx_state_t rx_state_r;
  logic [sync_line_pkg::HUNT_W-1:0] hunt_sr_r, hunt_nxt;
  logic [sync_line_pkg::MAX_FRAME-1:0] rx_sr_r, word_nxt, fill_bits, nmask;
  logic [3:0] rx_cnt_r, hunt_fill_r, rx_n;
  logic [1:0] hold_cnt_r;
  logic second_r, hunt_match, word_match, word_done;
  logic store_evt, store_frm, store_is_fill;
  logic [sync_line_pkg::MAX_FRAME-1:0] store_word;
  sync_line_pkg::frame_t fill_frame;

  // expected fill pattern, data plus parity, no start or stop
  assign fill_frame = build_frame(fill_r, param_r, 1'b0);
  assign rx_n = iso ? fill_frame.count : fill_frame.count;
  assign nmask = low_mask(rx_n);
  assign fill_bits = fill_frame.bits & nmask;

  // hunt window and word assembly, compared bit by bit as the line shifts
  always_comb begin
    hunt_nxt = {rx_bit, hunt_sr_r[sync_line_pkg::HUNT_W-1:1]};
    // compared in the counter's own width, so a saturated count never wraps to zero
    hunt_match = (hunt_fill_r >= rx_n - 4'h1) &&
                 ((11'(hunt_nxt >> (4'(sync_line_pkg::HUNT_W) - rx_n)) & nmask) == fill_bits);
    word_nxt = rx_sr_r;
    word_nxt[rx_cnt_r] = rx_bit;
    word_match = ((word_nxt & nmask) == fill_bits);
    word_done = rx_rise & (rx_state_r == RX_DATA) & (rx_cnt_r == rx_n - 4'h1);
    store_word = word_nxt;
    store_frm = 1'b0;
    store_evt = 1'b0;
    if (rx_en & rx_rise & (rx_state_r == RX_HUNT) & hunt_match & ~TWO_FILL_HUNT) begin
      store_evt = 1'b1;
      store_word = 11'(hunt_nxt >> (4'(sync_line_pkg::HUNT_W) - rx_n));
    end else if (rx_en & word_done & ~iso & (~second_r | word_match)) begin
      store_evt = 1'b1;
    end else if (rx_en & rx_rise & (rx_state_r == RX_STOP)) begin
      store_evt = 1'b1;
      store_word = rx_sr_r;
      store_frm = ~rx_bit;
    end
    store_is_fill = ~iso & ((store_word & nmask) == fill_bits);
  end

  // framing state machine; losing enable throws away any partial character
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rx_state_r <= RX_OFF;
      synced_r <= 1'b0;
      hunt_sr_r <= '0;
      rx_sr_r <= '0;
      rx_cnt_r <= 4'h0;
      hunt_fill_r <= 4'h0;
      hold_cnt_r <= 2'h0;
      second_r <= 1'b0;
    end else if (ce) begin
      if (mclr | ~rx_en) begin
        rx_state_r <= RX_OFF;
        synced_r <= 1'b0;
        second_r <= 1'b0;
      end else begin
        unique case (rx_state_r)
          RX_OFF: begin
            hunt_fill_r <= 4'h0;
            rx_cnt_r <= 4'h0;
            if (param_r.mode == sync_line_pkg::MODE_EXT_SYNC) begin
              synced_r <= 1'b1;
              rx_state_r <= RX_DATA;
            end else if (iso) begin
              synced_r <= 1'b1;
              rx_state_r <= RX_START;
            end else begin
              rx_state_r <= RX_HUNT;
            end
          end
          RX_HUNT: if (rx_rise) begin
            hunt_sr_r <= hunt_nxt;
            if (hunt_fill_r != 4'hF) hunt_fill_r <= hunt_fill_r + 4'h1;
            if (hunt_match) begin
              rx_state_r <= RX_DATA;
              rx_cnt_r <= 4'h0;
              synced_r <= ~TWO_FILL_HUNT;
              second_r <= TWO_FILL_HUNT;
            end
          end
          RX_HOLD: if (rx_rise) begin
            hold_cnt_r <= hold_cnt_r + 2'h1;
            if (hold_cnt_r == sync_line_pkg::HOLD_BITS - 2'h1) begin
              rx_state_r <= RX_HUNT;
              hunt_fill_r <= 4'h0;
            end
          end
          RX_START: if (rx_rise & ~rx_bit) begin
            rx_state_r <= RX_DATA;
            rx_cnt_r <= 4'h0;
          end
          RX_DATA: if (rx_rise) begin
            rx_sr_r <= word_nxt;
            rx_cnt_r <= rx_cnt_r + 4'h1;
            if (word_done) begin
              rx_cnt_r <= 4'h0;
              if (iso) begin
                rx_state_r <= RX_STOP;
              end else if (second_r & ~word_match) begin
                rx_state_r <= RX_HOLD;
                hold_cnt_r <= 2'h0;
                second_r <= 1'b0;
              end else if (second_r) begin
                synced_r <= 1'b1;
                second_r <= 1'b0;
              end
            end
          end
          RX_STOP: if (rx_rise) rx_state_r <= RX_START;
          default: rx_state_r <= RX_OFF;
        endcase
      end
    end
  end

  // holding buffer and its flags; a new character wins over a same-cycle read
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rxbuf_r <= 8'h00;
      {ready_r, ovr_r, frm_r, rx_req_r} <= 4'h0;
    end else if (ce) begin
      if (mclr) begin
        {ready_r, ovr_r, frm_r, rx_req_r} <= 4'h0;
      end else if (store_evt) begin
        rxbuf_r <= store_word[7:0] & (8'hFF >> (4'h8 - sync_line_pkg::MIN_CHAR_LEN -
                   {2'h0, param_r.len_code}));
        ready_r <= 1'b1;
        if (ready_r) ovr_r <= 1'b1;
        frm_r <= store_frm;
        if (rx_en_irq_r & ~(discard_r & store_is_fill & ~store_frm)) rx_req_r <= 1'b1;
      end else if (rd_rxbuf) begin
        {ready_r, ovr_r, frm_r, rx_req_r} <= 4'h0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read data, line and interrupt outputs
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata <= 8'h00;
    end else if (ce) begin
      rdata <= 8'h00;
      if (rd) begin
        unique case (addr)
          sync_line_pkg::ADDR_RX_CSR:
            rdata <= {1'b0, frm_r, ovr_r, ready_r, synced_r, rx_en_irq_r, discard_r, hunt_r};
          sync_line_pkg::ADDR_RX_BUF: rdata <= rxbuf_r;
          sync_line_pkg::ADDR_PARAM: rdata <= {2'h0, param_r};
          sync_line_pkg::ADDR_FILL: rdata <= fill_r;
          sync_line_pkg::ADDR_TX_CSR:
            rdata <= {2'h0, urun_r, taken_r, urun_en_r, taken_en_r, hd_r, send_r};
          default: rdata <= 8'h00; // holding buffer is write-only
        endcase
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tx_data_out <= 1'b1;
      irq_req <= 1'b0;
      irq_from_rx <= 1'b0;
    end else if (ce) begin
      tx_data_out <= tx_line_r;
      irq_req <= rx_req_r | tx_req_r;
      irq_from_rx <= rx_req_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  chk_fill_after_clear: assert property (@(posedge clk) disable iff (rst)
    mclr |=> fill_r == sync_line_pkg::FILL_RST) else $error("fill not ones after clear");
  chk_underrun_read_clr: assert property (@(posedge clk) disable iff (rst)
    rd_tx_control_status && !urun_evt && !mclr |=> !urun_r) else $error("underrun survived read");
  chk_taken_sets: assert property (@(posedge clk) disable iff (rst)
    taken_evt && !mclr |=> taken_r ##1 tx_data_out == $past(tx_line_r))
    else $error("taken flag missed");
  chk_underrun_irq: assert property (@(posedge clk) disable iff (rst)
    urun_evt && urun_en_r && !mclr |=> tx_req_r ##1 irq_req) else $error("underrun irq missed");
  chk_idle_mark: assert property (@(posedge clk) disable iff (rst)
    go_idle && !mclr |=> tx_line_r ##1 tx_data_out) else $error("line not mark when idle");
  chk_hunt_drop: assert property (@(posedge clk) disable iff (rst)
    ce && !hunt_r |=> !synced_r && rx_state_r == RX_OFF) else $error("sync kept without hunt");
  chk_overrun_set: assert property (@(posedge clk) disable iff (rst)
    store_evt && ready_r && !mclr |=> ovr_r && ready_r) else $error("overrun not flagged");
  chk_ext_sync: assert property (@(posedge clk) disable iff (rst)
    ce && rx_en && rx_state_r == RX_OFF && param_r.mode == sync_line_pkg::MODE_EXT_SYNC
    && !mclr |=> synced_r && rx_state_r == RX_DATA) else $error("external sync late");
  chk_rx_priority: assert property (@(posedge clk) disable iff (rst)
    ce && rx_req_r && tx_req_r |=> irq_req && irq_from_rx) else $error("tx granted over rx");
  chk_fill_insert: assert property (@(posedge clk) disable iff (rst)
    tx_fall && at_end && send_r && !buf_full_r && !iso && !mclr |=> tx_src_fill_r
    && tx_line_r == fill_frame.bits[0]) else $error("fill not inserted");
endmodule // sync_serial_line_tx_rx
`default_nettype wire

// File: bench/line_modem_model.sv
// behavioural modem: free line clock, serial source and sink
`timescale 1ns/10ps
`default_nettype none
module line_modem_model (
  // line side
  input wire logic tx_data,
  output logic line_clk,
  output logic rx_data
);
  logic [31:0] cap;
  // a synchronous modem clock runs free, the line rests at mark
  initial begin
    line_clk = 1'b0;
    rx_data = 1'b1;
    cap = 32'h0;
    forever #200 line_clk = ~line_clk;
  end
  // rising edge sits clear of the delayed bit change after the falling edge
  always @(posedge line_clk) cap <= {tx_data, cap[31:1]};
  // first bit goes out at once, the rest on falling edges
  task automatic send(input logic [15:0] v, input int n);
    for (int i = 0; i < n; i++) begin
      if (i > 0) @(negedge line_clk);
      rx_data = v[i];
    end
    @(negedge line_clk);
    rx_data = 1'b1;
  endtask
endmodule // line_modem_model
`default_nettype wire

// File: bench/sync_serial_line_tx_rx_tb.sv
// self-checking bench for the serial line transmitter/receiver
`timescale 1ns/10ps
`default_nettype none
module sync_serial_line_tx_rx_tb;
  logic clk, rst, wr, rd, lclk, rxd, txd, irq, irq_rx;
  logic [2:0] addr;
  logic [7:0] wdata, rdata, d;
  int n_errors = 0;
  int n_checks = 0;
  sync_serial_line_tx_rx sync_serial_line_tx_rx_inst (.clk(clk), .rst(rst), .ce(1'b1),
    .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .tx_line_clk(lclk),
    .rx_line_clk(lclk), .rx_data_in(rxd), .tx_data_out(txd), .irq_req(irq),
    .irq_from_rx(irq_rx));
  line_modem_model line_modem_model_inst (.tx_data(txd), .line_clk(lclk), .rx_data(rxd));
  //////////////////////////////////////////////////////////////////////////////
  // compare and count
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // one-cycle write strobe
  task automatic wreg(input logic [2:0] a, input logic [7:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  // read data stands only in the cycle after the strobe
  task automatic rreg(input logic [2:0] a);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    d = rdata;
  endtask
  // bounded poll; note each read of tx status clears underrun
  task automatic poll(input logic [2:0] a, input int b);
    for (int i = 0; i < 300; i++) begin
      rreg(a);
      if (d[b] === 1'b1) break;
    end
  endtask
  task automatic end_of_test();
    if (n_errors == 0 && n_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // the sequence needs well under a tenth of this
  initial begin
    #2000000;
    n_errors++;
    end_of_test();
  end
  initial begin
    rst = 1'b1;
    addr = 3'h0;
    wdata = 8'h00;
    wr = 1'b0;
    rd = 1'b0;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    // fill register after reset and after master clear
    rreg(sync_line_pkg::ADDR_FILL);
    check(d, 8'hFF);
    wreg(sync_line_pkg::ADDR_FILL, 8'h16);
    wreg(sync_line_pkg::ADDR_PARAM, 8'h80);
    rreg(sync_line_pkg::ADDR_FILL);
    check(d, 8'hFF);
    // external sync: framing starts on the very next bit
    wreg(sync_line_pkg::ADDR_PARAM, 8'h1C);
    @(negedge lclk);
    wreg(sync_line_pkg::ADDR_RX_CSR, 8'h05);
    line_modem_model_inst.send(16'h00A5, 8);
    poll(sync_line_pkg::ADDR_RX_CSR, 4);
    check(d, 8'h1D);
    check({7'h0, irq_rx}, 8'h01);
    rreg(sync_line_pkg::ADDR_RX_BUF);
    check(d, 8'hA5);
    // two characters unread: second overwrites the first
    line_modem_model_inst.send(16'h5A3C, 16);
    repeat (20) @(posedge clk);
    rreg(sync_line_pkg::ADDR_RX_CSR);
    check(d, 8'h3D);
    rreg(sync_line_pkg::ADDR_RX_BUF);
    check(d, 8'h5A);
    wreg(sync_line_pkg::ADDR_RX_CSR, 8'h00);
    rreg(sync_line_pkg::ADDR_RX_CSR);
    check(d, 8'h00);
    // isochronous character with a space where the stop bit belongs
    wreg(sync_line_pkg::ADDR_PARAM, 8'h2C);
    // start bit must stand across a whole line clock, so align to its falling edge
    @(negedge lclk);
    wreg(sync_line_pkg::ADDR_RX_CSR, 8'h01);
    line_modem_model_inst.send(16'h0186, 10);
    poll(sync_line_pkg::ADDR_RX_CSR, 4);
    check(d, 8'h59);
    rreg(sync_line_pkg::ADDR_RX_BUF);
    check(d, 8'hC3);
    wreg(sync_line_pkg::ADDR_RX_CSR, 8'h00);
    // internal sync: hunt over five fills, then a message character and a non-fill pad
    wreg(sync_line_pkg::ADDR_PARAM, 8'h0C);
    wreg(sync_line_pkg::ADDR_FILL, 8'h16);
    wreg(sync_line_pkg::ADDR_RX_CSR, 8'h05);
    line_modem_model_inst.send(16'h1616, 16);
    line_modem_model_inst.send(16'h1616, 16);
    line_modem_model_inst.send(16'hA516, 16);
    rreg(sync_line_pkg::ADDR_RX_CSR);
    check(d, 8'h3D);
    check({7'h0, irq_rx}, 8'h01);
    rreg(sync_line_pkg::ADDR_RX_BUF);
    check(d, 8'hA5);
    line_modem_model_inst.send(16'h0055, 8);
    repeat (20) @(posedge clk);
    rreg(sync_line_pkg::ADDR_RX_BUF);
    check(d, 8'h55);
    wreg(sync_line_pkg::ADDR_RX_CSR, 8'h00);
    // transmit: message, fill insertion, late message, then send off
    wreg(sync_line_pkg::ADDR_PARAM, 8'h0C);
    wreg(sync_line_pkg::ADDR_FILL, 8'h16);
    wreg(sync_line_pkg::ADDR_TX_CSR, 8'h09);
    wreg(sync_line_pkg::ADDR_TX_BUF, 8'h3C);
    poll(sync_line_pkg::ADDR_TX_CSR, 4);
    check(d & 8'h10, 8'h10);
    poll(sync_line_pkg::ADDR_TX_CSR, 5);
    check({6'h0, irq, irq_rx}, 8'h02);
    // one modem rising edge has taken the fill's first bit by the next falling edge
    @(negedge lclk);
    check(line_modem_model_inst.cap[30:23], 8'h3C);
    rreg(sync_line_pkg::ADDR_TX_CSR);
    check(d & 8'h20, 8'h00);
    poll(sync_line_pkg::ADDR_TX_CSR, 5);
    @(negedge lclk);
    check(line_modem_model_inst.cap[30:23], 8'h16);
    wreg(sync_line_pkg::ADDR_TX_BUF, 8'h5A);
    poll(sync_line_pkg::ADDR_TX_CSR, 5);
    @(negedge lclk);
    check(line_modem_model_inst.cap[30:23], 8'h5A);
    wreg(sync_line_pkg::ADDR_TX_CSR, 8'h00);
    repeat (150) @(posedge clk);
    check({7'h0, txd}, 8'h01);
    check(line_modem_model_inst.cap[31:24], 8'hFF);
    end_of_test();
  end
endmodule // sync_serial_line_tx_rx_tb
`default_nettype wire
